// ---- mbg_pkg.sv ----
package mbg_pkg;

   // ************************************************************
   // bus geometry
   // ************************************************************
   localparam int AD_W      = 32;
   localparam int LANE_W    = 4;
   localparam int LANE_LSB  = 0;
   localparam int ADDR_LSB  = 4;
   localparam int BANK_LSB  = 28;
   localparam int BANK_BITS = 2;
   localparam int NUM_BANKS = 4;
   localparam int WIDX_W    = 2;
   localparam int DIAG_W    = 2;

   // ************************************************************
   // reset values and constants
   // ************************************************************
   localparam logic [WIDX_W-1:0] WIDX_FIRST = 2'h0;
   localparam logic [WIDX_W-1:0] WIDX_LAST  = 2'h3;
   localparam logic [LANE_W-1:0] LANES_ALL  = 4'hf;
   localparam logic [LANE_W-1:0] LANES_NONE = 4'h0;
   localparam logic [AD_W-1:0]   ADDR_RST   = 32'h0000_0000;
   localparam logic [DIAG_W-1:0] DIAG_RST   = 2'h0;

   // processor-side control strobes, all as seen on the pins
   typedef struct packed {
      logic ale;
      logic rd_n;
      logic wr_n;
      logic burst_n;
      logic data_drive_en_n;
   } mbg_bus_ctl_type;

   typedef enum logic [1:0] {
      MBG_IDLE  = 2'b00,
      MBG_READ  = 2'b01,
      MBG_WRITE = 2'b10
   } mbg_cyc_type;

endpackage : mbg_pkg

// ---- mbg_cs_reg.sv ----
`timescale 1ns/100ps
`default_nettype none

module mbg_cs_reg
   import mbg_pkg::*;
#(
   parameter int NB = NUM_BANKS
) (
   input  wire logic            clk_in,
   input  wire logic            rst_in,
   input  wire logic            en_in,
   input  wire logic [AD_W-1:0] addr_in,
   output var  logic [NB-1:0]   cs_out
);

   function automatic logic [NB-1:0] bank_onehot(input logic [AD_W-1:0] a);
      logic [NB-1:0] r;
      r = '0;
      r[a[BANK_LSB +: BANK_BITS]] = 1'b1;
      return r;
   endfunction : bank_onehot

   // registered glitch-free selects
   // held until the next enable, so stable for the whole cycle
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cs_out <= '0;
      end else if (en_in) begin
         cs_out <= bank_onehot(addr_in);
      end
   end

   AST_CS_HOLD: assert property (@(posedge clk_in) disable iff (rst_in)
      !en_in |=> $stable(cs_out))
      else $error("bank select changed without cycle begin");

endmodule : mbg_cs_reg

`default_nettype wire

// ---- mbg_glue.sv ----
// Summary of operation
// - chip selects are registered on the clock, enabled by cycle begin
// - cycle begin pulses from read and write strobes at cycle start
// - byte lane selects ride on the lowest four bus lines in address phase
// - reads return the full word; all lanes enabled on reads
// - lane selects are valid with the address while latch strobe is high
// - word index inputs stand for the whole cycle, no latch needed
// - word index holds the word address in single reads and writes
// - in bursts word index steps zero to three per acknowledged word
// - a new cycle may begin right after the read data is taken
`timescale 1ns/100ps
`default_nettype none

module mbg_glue
   import mbg_pkg::*;
#(
   parameter int   NB          = NUM_BANKS,
   parameter logic LATE_WR_EN  = 1'b1
) (
   input  wire logic                   CLK_IN,
   input  wire logic                   RST_IN,
   input  wire logic [AD_W-1:0]        AD_IN,
   input  wire mbg_bus_ctl_type        BUS_CTL_IN,
   input  wire logic [WIDX_W-1:0]      WORD_IDX_IN,
   input  wire logic [DIAG_W-1:0]      DIAG_IN,
   input  wire logic                   MEM_WORD_READY_IN,
   output var  logic [AD_W-1:ADDR_LSB] ADDR_OUT,
   output var  logic [LANE_W-1:0]      BYTE_LANE_SELECT_OUT,
   output var  logic [WIDX_W-1:0]      WORD_IDX_OUT,
   output var  logic [DIAG_W-1:0]      FETCH_TYPE_OUT,
   output var  logic                   CYCLE_BEGIN_OUT,
   output var  logic [NB-1:0]          BANK_CS_OUT,
   output var  logic [NB*LANE_W-1:0]   BYTE_CS_OUT,
   output var  logic [LANE_W-1:0]      BYTE_WR_STROBE_OUT,
   output var  logic [LANE_W-1:0]      BYTE_RD_STROBE_OUT,
   output var  logic                   READ_WORD_ACK_N_OUT,
   output var  logic [NB-1:0]          XCVR_RD_EN_OUT,
   output var  logic                   XCVR_WR_EN_OUT
);

   // ************************************************************
   // decoded strobes
   // ************************************************************
   logic              rd;
   logic              wr;
   logic              burst;
   logic              drive_en;
   logic [AD_W-1:0]   addr_q;
   logic [AD_W-1:0]   addr_view;
   logic [LANE_W-1:0] lanes_view;
   logic [DIAG_W-1:0] diag_q;
   mbg_cyc_type       cyc_q;
   mbg_cyc_type       cyc_d;
   logic              cycle_begin;
   logic              wr_hold_q;

   assign rd       = !BUS_CTL_IN.rd_n;
   assign wr       = !BUS_CTL_IN.wr_n;
   assign burst    = !BUS_CTL_IN.burst_n;
   assign drive_en = !BUS_CTL_IN.data_drive_en_n;

   // ************************************************************
   // address latch
   // ************************************************************
   // transparent view
   // decode sees the bus while the strobe is high, the hold value after
   assign addr_view  = BUS_CTL_IN.ale ? AD_IN : addr_q;
   assign lanes_view = addr_view[LANE_LSB +: LANE_W];

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         addr_q <= ADDR_RST;
      end else if (BUS_CTL_IN.ale) begin
         addr_q <= AD_IN;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         diag_q <= DIAG_RST;
      end else if (BUS_CTL_IN.ale) begin
         diag_q <= DIAG_IN;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         ADDR_OUT             <= ADDR_RST[AD_W-1:ADDR_LSB];
         BYTE_LANE_SELECT_OUT <= LANES_NONE;
         FETCH_TYPE_OUT       <= DIAG_RST;
      end else begin
         ADDR_OUT             <= addr_view[AD_W-1:ADDR_LSB];
         BYTE_LANE_SELECT_OUT <= lanes_view;
         FETCH_TYPE_OUT       <= BUS_CTL_IN.ale ? DIAG_IN : diag_q;
      end
   end

   // ************************************************************
   // cycle tracking
   // ************************************************************
   always_comb begin
      cyc_d = MBG_IDLE;
      if (wr) begin
         cyc_d = MBG_WRITE;
      end else if (rd) begin
         cyc_d = MBG_READ;
      end
   end

   // back-to-back cycles: a change of kind is a new cycle too
   assign cycle_begin = (cyc_d != MBG_IDLE) && (cyc_d != cyc_q);

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         cyc_q           <= MBG_IDLE;
         CYCLE_BEGIN_OUT <= 1'b0;
      end else begin
         cyc_q           <= cyc_d;
         CYCLE_BEGIN_OUT <= cycle_begin;
      end
   end

   // ************************************************************
   // chip selects
   // ************************************************************
   mbg_cs_reg #(
      .NB      (NB)
   ) u_cs (
      .clk_in  (CLK_IN),
      .rst_in  (RST_IN),
      .en_in   (cycle_begin),
      .addr_in (addr_view),
      .cs_out  (BANK_CS_OUT)
   );

   // reads open every lane; the processor drops unwanted bytes
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         BYTE_CS_OUT <= '0;
      end else if (cycle_begin) begin
         for (int b = 0; b < NB; b++) begin
            BYTE_CS_OUT[b*LANE_W +: LANE_W] <=
               (addr_view[BANK_LSB +: BANK_BITS] == BANK_BITS'(b)) ?
               (wr ? lanes_view : LANES_ALL) : LANES_NONE;
         end
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         BYTE_WR_STROBE_OUT <= LANES_NONE;
         BYTE_RD_STROBE_OUT <= LANES_NONE;
      end else begin
         BYTE_WR_STROBE_OUT <= wr ? lanes_view : LANES_NONE;
         BYTE_RD_STROBE_OUT <= (rd && !wr) ? LANES_ALL : LANES_NONE;
      end
   end

   // ************************************************************
   // word index and read acknowledge
   // ************************************************************
   // no latch, buffered copy
   // single word index follows pins; bursts step on the pins
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         WORD_IDX_OUT <= WIDX_FIRST;
      end else begin
         WORD_IDX_OUT <= WORD_IDX_IN;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         READ_WORD_ACK_N_OUT <= 1'b1;
      end else begin
         READ_WORD_ACK_N_OUT <= !(MEM_WORD_READY_IN && rd);
      end
   end

   // ************************************************************
   // transceiver enables
   // ************************************************************
   // one read enable per bank, gated by its bank select
   // drops at the clock after drive enable, inside a next address phase that follows at once
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         XCVR_RD_EN_OUT <= '0;
      end else begin
         XCVR_RD_EN_OUT <= (drive_en && rd) ? BANK_CS_OUT : '0;
      end
   end

   // write enable hold
   // one extra cycle covers memory hold after the write strobe drops
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         wr_hold_q      <= 1'b0;
         XCVR_WR_EN_OUT <= 1'b0;
      end else begin
         wr_hold_q      <= wr;
         XCVR_WR_EN_OUT <= (wr && !BUS_CTL_IN.ale &&
                           !(LATE_WR_EN && cycle_begin)) ||
                           (wr_hold_q && !wr && XCVR_WR_EN_OUT);
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   AST_CYCLE_BEGIN: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      $rose(wr || rd) |-> ##1 CYCLE_BEGIN_OUT)
      else $error("no cycle begin at strobe assertion");

   AST_WR_LANES: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      (wr && !BUS_CTL_IN.ale) |=>
      (BYTE_WR_STROBE_OUT & ~$past(lanes_view)) == LANES_NONE)
      else $error("write strobe on unselected byte");

   AST_RD_FULL: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      (rd && !wr) |=> BYTE_RD_STROBE_OUT == LANES_ALL)
      else $error("read does not open all lanes");

   AST_LANE_LATCH: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      $fell(BUS_CTL_IN.ale) |=> BYTE_LANE_SELECT_OUT ==
      $past(AD_IN[LANE_LSB +: LANE_W], 2))
      else $error("byte lanes not held after latch closes");

   AST_XCVR_RD: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      ##1 (XCVR_RD_EN_OUT & ~$past(BANK_CS_OUT)) == '0)
      else $error("unselected bank drives read data");

   AST_WR_EN_LATE: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      (LATE_WR_EN && cycle_begin) |=> !XCVR_WR_EN_OUT)
      else $error("write enable during address phase");

   AST_WR_EN_HOLD: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      $fell(wr) ##0 XCVR_WR_EN_OUT |=> XCVR_WR_EN_OUT ##1 !XCVR_WR_EN_OUT)
      else $error("write enable not held one cycle after strobe");

   AST_WIDX_STABLE: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      (wr && $past(wr)) |=> $stable(WORD_IDX_OUT))
      else $error("word index moved inside write");

   AST_BURST_FIRST: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      (cycle_begin && rd && burst) |=> WORD_IDX_OUT == WIDX_FIRST)
      else $error("burst does not start at word zero");

   CVR_WRITE: cover property (@(posedge CLK_IN) disable iff (RST_IN)
      cycle_begin && wr ##[1:8] XCVR_WR_EN_OUT);
   CVR_BURST: cover property (@(posedge CLK_IN) disable iff (RST_IN)
      rd && burst && WORD_IDX_OUT == WIDX_LAST);
   CVR_RD_WR: cover property (@(posedge CLK_IN) disable iff (RST_IN)
      cyc_q == MBG_READ && cyc_d == MBG_WRITE);

endmodule : mbg_glue

`default_nettype wire

// ---- mbg_cpu_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module mbg_cpu_model
   import mbg_pkg::*;
(
   input  wire logic              clk_in,
   input  wire logic              ack_n_in,
   output var  logic [AD_W-1:0]   ad_out,
   output var  mbg_bus_ctl_type   ctl_out,
   output var  logic [WIDX_W-1:0] widx_out,
   output var  logic [DIAG_W-1:0] diag_out
);
   // ****
   // processor side, entered and left at a falling edge
   // ****
   initial begin
      ad_out   = '0;
      ctl_out  = 5'h0f;
      widx_out = WIDX_FIRST;
      diag_out = DIAG_RST;
   end

   task automatic run(input logic wr, input logic [AD_W-1:0] a,
      input logic [WIDX_W-1:0] w, input logic [DIAG_W-1:0] dg,
      input logic bst, input int waits, output logic ok);
      int n;
      int i;
      n = 0;
      i = 0;
      ad_out      = a;
      ctl_out.ale = 1'b1;
      diag_out    = dg;
      widx_out        = bst ? WIDX_FIRST : w;
      ctl_out.burst_n = !bst;
      @(negedge clk_in);
      ctl_out.ale  = 1'b0;
      ctl_out.rd_n = wr;
      ctl_out.wr_n = !wr;
      // released bus shows the inverted address, inverted again on each clock while a read waits for its words
      ad_out = ~a;
      if (wr) begin
         repeat (waits) @(negedge clk_in);
         ctl_out.wr_n = 1'b1;
         // write data held one cycle past the strobe
         @(negedge clk_in);
      end
      while (!wr && n < (bst ? 4 : 1) && i < 200) begin
         @(negedge clk_in);
         i++;
         ad_out = ~ad_out;
         ctl_out.data_drive_en_n = 1'b0;
         if (!ack_n_in) begin
            n++;
            if (bst) widx_out = widx_out + 2'h1;
         end
      end
      ok = wr || n == (bst ? 4 : 1);
      // next address may follow at once
      ctl_out.rd_n            = 1'b1;
      ctl_out.data_drive_en_n = 1'b1;
   endtask : run
endmodule : mbg_cpu_model

`default_nettype wire

// ---- tb_muxed_bus_memory_glue.sv ----
`timescale 1ns/100ps
`default_nettype none

module tb_muxed_bus_memory_glue
   import mbg_pkg::*;
;
   logic                        clk;
   logic                        rst;
   logic                        rdy;
   logic                        p_wr;
   logic                        p_rd;
   logic [AD_W-1:0]             ad;
   mbg_bus_ctl_type             ctl;
   logic [WIDX_W-1:0]           widx;
   logic [DIAG_W-1:0]           dg;
   logic [AD_W-1:ADDR_LSB]      addr_o;
   logic [AD_W-1:ADDR_LSB]      e_addr;
   logic [LANE_W-1:0]           lane_o;
   logic [LANE_W-1:0]           wrs_o;
   logic [LANE_W-1:0]           rds_o;
   logic [LANE_W-1:0]           e_lane;
   logic [WIDX_W-1:0]           widx_o;
   logic [DIAG_W-1:0]           ft_o;
   logic [DIAG_W-1:0]           e_dg;
   logic                        cb_o;
   logic                        ackn_o;
   logic                        wen_o;
   logic [NUM_BANKS-1:0]        cs_o;
   logic [NUM_BANKS-1:0]        xrd_o;
   logic [NUM_BANKS-1:0]        e_cs;
   logic [NUM_BANKS*LANE_W-1:0] bcs_o;
   logic [NUM_BANKS*LANE_W-1:0] e_bcs;
   int                          fails;
   int                          cmp_count;
   int                          seed = 31;

   mbg_cpu_model cpu_u (.clk_in(clk), .ack_n_in(ackn_o), .ad_out(ad),
      .ctl_out(ctl), .widx_out(widx), .diag_out(dg));

   mbg_glue dut_u (.CLK_IN(clk), .RST_IN(rst), .AD_IN(ad),
      .BUS_CTL_IN(ctl), .WORD_IDX_IN(widx), .DIAG_IN(dg),
      .MEM_WORD_READY_IN(rdy), .ADDR_OUT(addr_o),
      .BYTE_LANE_SELECT_OUT(lane_o), .WORD_IDX_OUT(widx_o),
      .FETCH_TYPE_OUT(ft_o), .CYCLE_BEGIN_OUT(cb_o), .BANK_CS_OUT(cs_o),
      .BYTE_CS_OUT(bcs_o), .BYTE_WR_STROBE_OUT(wrs_o),
      .BYTE_RD_STROBE_OUT(rds_o), .READ_WORD_ACK_N_OUT(ackn_o),
      .XCVR_RD_EN_OUT(xrd_o), .XCVR_WR_EN_OUT(wen_o));

   // ****
   // clock, memory readiness, checks
   // ****
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // memory answers at random so acks come both fast and slow
   always @(negedge clk) rdy <= !ctl.rd_n && (($random(seed) & 3) != 0);

   task automatic chk(input logic [31:0] g, input logic [31:0] e,
      input string m);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
      end
   endtask : chk

   task automatic end_sim;
      $display("comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : end_sim

   always @(posedge clk) begin : mon
      logic wr;
      logic rd;
      logic cb;
      logic [NUM_BANKS-1:0] x_rd;
      logic e_wen;
      #1;
      wr   = !rst && !ctl.wr_n;
      rd   = !rst && !ctl.rd_n && ctl.wr_n;
      cb   = (wr && !p_wr) || (rd && !p_rd);
      x_rd = (rd && !ctl.data_drive_en_n) ? e_cs : '0;
      if (rst) begin
         {e_addr, e_lane, e_dg, e_cs, e_bcs} = '0;
      end else if (ctl.ale) begin
         e_addr = ad[AD_W-1:ADDR_LSB];
         e_lane = ad[LANE_W-1:0];
         e_dg   = dg;
      end
      if (cb) begin
         e_cs  = 4'h1 << e_addr[BANK_LSB+:BANK_BITS];
         e_bcs = 16'(wr ? e_lane : LANES_ALL) << (4 * e_addr[29:28]);
      end
      chk(32'(addr_o), 32'(e_addr), "address");
      chk(32'(lane_o), 32'(e_lane), "lanes");
      chk(32'(ft_o), 32'(e_dg), "fetch type");
      chk(32'(widx_o), 32'(rst ? '0 : widx), "word index");
      chk(32'(cb_o), 32'(cb), "cycle begin");
      chk(32'(cs_o), 32'(e_cs), "bank select");
      chk(32'(bcs_o), 32'(e_bcs), "byte selects");
      chk(32'(wrs_o), 32'(wr ? e_lane : LANES_NONE), "wr strobe");
      chk(32'(rds_o), 32'(rd ? LANES_ALL : LANES_NONE), "rd strobe");
      chk(32'(ackn_o), 32'(!(rdy && rd)), "read ack");
      chk(32'(xrd_o), 32'(x_rd), "read enable");
      // the hold cycle only extends an enable that was already up
      e_wen = wr && !cb && !ctl.ale || p_wr && !wr && e_wen;
      chk(32'(wen_o), 32'(e_wen), "write enable");
      p_wr = wr;
      p_rd = rd;
   end

   // ****
   // corner cases first, then random cycles, then a mid-run reset
   // ****
   initial begin : main
      logic ok;
      logic wr;
      logic [AD_W-1:0] a;
      int k;
      {rst, rdy, p_wr, p_rd} = 4'h8;
      fails     = 0;
      cmp_count = 0;
      repeat (5) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      for (k = 0; k < 62; k++) begin
         a  = $random(seed);
         wr = k < 4 || (k >= 8 && a[31]);
         if (k < 8) begin
            a[29:28] = k[1:0];
            a[3:0]   = 4'h1 << k[1:0];
         end
         if (k == 60) begin
            rst = 1'b1;
            repeat (2) @(negedge clk);
            rst = 1'b0;
         end
         if (wr && a[3:0] == LANES_NONE) a[3:0] = LANES_ALL;
         cpu_u.run(wr, a, a[7:6], a[9:8], !wr && k[0],
            k < 8 ? 1 : 1 + a[11:10], ok);
         $display("test %0d done, write %0b", k, wr);
         if (!ok) begin
            fails++;
            $display("wrong value at %0t: read ack missing", $time);
            end_sim();
         end
      end
      repeat (3) @(negedge clk);
      end_sim();
   end
endmodule : tb_muxed_bus_memory_glue

`default_nettype wire
